//--- src/readout_pkg.sv
// constants, field layouts and carriers for the slave-mode readout block
// assumes a single 100 MHz clock and an ahb-lite master on the same clock
// Operation
// R1 - video select 0 passes internal pixel video, 1 passes the external input
// R2 - controller drives every mode input to a level in slave mode, never floating
// R3 - two-bit sampling mode picks standard, snapshot, accumulate or transfer readout
// R4 - accumulate mode outputs raw samples; controller then switches to mode 1 (the controller model holds whatever mode it is given)
// R5 - column binning 1X keeps full horizontal resolution, no combining
// R6 - column binning 2X sums column pairs, 4X sums groups of four
// R7 - row binning 1X keeps full vertical resolution, no combining
// R8 - row binning 4X sums groups of four rows, 2X sums row pairs
// R9 - controller pulls row start strobe low 1.1 clocks to start readout
// R10 - binning codes 00, 01, 10 mean 1X, 2X, 4X; 11 is reserved
package readout_pkg;

    // ****************************************
    // widths and sizes
    // ****************************************
    localparam int SAMPLE_W = 10;
    localparam int SUM_W = 14;
    localparam int LINE_COLS = 1026;
    localparam int COL_ADDR_W = 11;
    localparam int ROW_PH_W = 2;

    // ****************************************
    // mode codes
    // ****************************************
    localparam logic [1:0] SMODE_STANDARD = 2'h0;
    localparam logic [1:0] SMODE_SNAPSHOT = 2'h1;
    localparam logic [1:0] SMODE_ACCUM = 2'h2;
    localparam logic [1:0] SMODE_TRANSFER = 2'h3;
    localparam logic [1:0] BIN_1X = 2'h0;
    localparam logic [1:0] BIN_2X = 2'h1;
    localparam logic [1:0] BIN_4X = 2'h2;
    localparam logic [1:0] BIN_RSVD = 2'h3;
    localparam logic VIDEO_INTERNAL = 1'b0;
    localparam logic VIDEO_EXTERNAL = 1'b1;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam int CTRL_PIN_MODE = 0;
    localparam int FLD_VIDEO = 1;
    localparam int FLD_SMODE = 2;
    localparam int FLD_COLBIN = 4;
    localparam int FLD_ROWBIN = 6;
    localparam int STAT_RSVD = 8;
    localparam int STAT_ROWPH = 9;
    localparam logic CTRL_PIN_MODE_RST = 1'b1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic video_sel;
        logic [1:0] sample_mode;
        logic [1:0] col_bin;
        logic [1:0] row_bin;
    } mode_s;

    localparam mode_s MODE_RST = '{VIDEO_INTERNAL, SMODE_STANDARD, BIN_1X, BIN_1X};

    typedef struct packed {
        logic valid;
        logic last;
        logic [SUM_W-1:0] sum;
        logic [COL_ADDR_W-1:0] addr;
        logic [ROW_PH_W-1:0] ph;
    } bin_s;

    // group size minus one; reserved code behaves as 1X
    function automatic logic [1:0] bin_last(input logic [1:0] code);
        case (code)
            BIN_2X: bin_last = 2'h1;
            BIN_4X: bin_last = 2'h3;
            default: bin_last = 2'h0;
        endcase
    endfunction : bin_last

endpackage : readout_pkg

//--- src/line_sum_mem.sv
// one line of partial row sums, one word per binned column
// assumes data read from a word in the cycle it is written is never used
`timescale 1ns/1ps
module line_sum_mem #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 1026,
    parameter int AW = 11
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read: data one cycle after the address
    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end
endmodule : line_sum_mem

//--- src/mode_readout.sv
// readout path steered by the slave-mode select pins or by a control register
// assumes pixel samples arrive on CLOCK; mode pins are asynchronous
`timescale 1ns/1ps
module mode_readout (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic VIDEO_SOURCE_SELECT,
    input wire logic SAMPLE_MODE_HI,
    input wire logic SAMPLE_MODE_LO,
    input wire logic COL_BIN_HI,
    input wire logic COL_BIN_LO,
    input wire logic ROW_BIN_HI,
    input wire logic ROW_BIN_LO,
    input wire logic IN_FRAME_START,
    input wire logic IN_VALID,
    input wire logic IN_LINE_END,
    input wire logic [readout_pkg::SAMPLE_W-1:0] IN_PIX_INT,
    input wire logic [readout_pkg::SAMPLE_W-1:0] IN_RESET_LEVEL,
    input wire logic [readout_pkg::SAMPLE_W-1:0] IN_PIX_EXT,
    output logic OUT_VALID,
    output logic [readout_pkg::SUM_W-1:0] OUT_PIXEL,
    output logic OUT_CDS_EN,
    output logic [1:0] OUT_SAMPLE_MODE
);
    import readout_pkg::*;

    // ****************************************
    // mode pin synchroniser
    // ****************************************
    mode_s pin_meta;
    mode_s pin_sync;
    mode_s ctrl_mode;
    logic pin_mode;
    mode_s sel;
    mode_s bin_mode;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pin_meta <= MODE_RST;
            pin_sync <= MODE_RST;
        end else begin
            pin_meta <= '{VIDEO_SOURCE_SELECT, {SAMPLE_MODE_HI, SAMPLE_MODE_LO},
                          {COL_BIN_HI, COL_BIN_LO}, {ROW_BIN_HI, ROW_BIN_LO}};
            pin_sync <= pin_meta;
        end
    end

    // pins only mean something when the controller drives them [R2]
    assign sel = pin_mode ? pin_sync : ctrl_mode;

    // binning held per frame so a row group is never torn
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            bin_mode <= MODE_RST;
        end else if (IN_FRAME_START) begin
            bin_mode <= sel;
        end
    end

    logic [1:0] col_last;
    logic [1:0] row_last;
    assign col_last = bin_last(bin_mode.col_bin); // [R10]
    assign row_last = bin_last(bin_mode.row_bin); // [R10]

    // ****************************************
    // source select and double sampling
    // ****************************************
    logic s0_valid;
    logic s0_last;
    logic [SAMPLE_W-1:0] s0_val;
    logic cds_on;
    assign cds_on = (sel.sample_mode != SMODE_ACCUM); // [R3] [R4]

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            s0_valid <= 1'b0;
            s0_last <= 1'b0;
            s0_val <= '0;
        end else begin
            s0_valid <= IN_VALID;
            s0_last <= IN_VALID && IN_LINE_END;
            if (sel.video_sel == VIDEO_EXTERNAL) begin
                s0_val <= IN_PIX_EXT; // [R1]
            end else if (!cds_on || IN_PIX_INT < IN_RESET_LEVEL) begin
                // accumulate passes raw charge; cds clamps at black
                s0_val <= cds_on ? '0 : IN_PIX_INT; // [R4]
            end else begin
                s0_val <= IN_PIX_INT - IN_RESET_LEVEL; // [R1] [R3]
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            OUT_CDS_EN <= 1'b1;
            OUT_SAMPLE_MODE <= SMODE_STANDARD;
        end else begin
            OUT_CDS_EN <= cds_on; // [R3]
            OUT_SAMPLE_MODE <= sel.sample_mode; // [R3]
        end
    end

    // ****************************************
    // column binning
    // ****************************************
    logic [1:0] col_cnt;
    logic [SUM_W-1:0] col_acc;
    logic [SUM_W-1:0] next_col_sum;
    logic [ROW_PH_W-1:0] row_phase;
    bin_s c;
    bin_s d;
    logic [COL_ADDR_W-1:0] col_addr;

    assign next_col_sum = (col_cnt == 2'h0 ? '0 : col_acc) + SUM_W'(s0_val);

    // word address counts emitted groups, so gaps between samples cannot skew it
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            col_cnt <= 2'h0;
            col_acc <= '0;
            col_addr <= '0;
            c <= '0;
        end else begin
            c.valid <= 1'b0;
            if (IN_FRAME_START) begin
                col_cnt <= 2'h0;
                col_addr <= '0;
            end else if (s0_valid) begin
                if (col_cnt == col_last || s0_last) begin
                    c.valid <= 1'b1; // [R5] [R6]
                    c.sum <= next_col_sum;
                    c.last <= s0_last;
                    c.ph <= row_phase;
                    c.addr <= col_addr;
                    col_addr <= s0_last ? '0 : col_addr + COL_ADDR_W'(1);
                    col_cnt <= 2'h0;
                end else begin
                    col_acc <= next_col_sum; // [R6]
                    col_cnt <= col_cnt + 2'h1;
                end
            end
        end
    end

    // ****************************************
    // row binning over the line memory
    // ****************************************
    logic [SUM_W-1:0] rd_data;
    logic [SUM_W-1:0] next_row_sum;

    // steps as a line's last sample enters the column stage, so a 1x column
    // group right behind it already carries the new phase
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            row_phase <= '0;
        end else if (IN_FRAME_START) begin
            row_phase <= '0;
        end else if (s0_valid && s0_last) begin
            row_phase <= (row_phase == ROW_PH_W'(row_last)) ? '0 : row_phase + ROW_PH_W'(1); // [R7] [R8]
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            d <= '0;
        end else begin
            d <= c;
        end
    end

    assign next_row_sum = (d.ph == '0) ? d.sum : SUM_W'(d.sum + rd_data); // [R8]

    line_sum_mem #(
        .WIDTH(SUM_W),
        .DEPTH(LINE_COLS),
        .AW(COL_ADDR_W)
    ) u_line (
        .clock(CLOCK),
        .wr_en(d.valid),
        .wr_addr(d.addr),
        .wr_data(next_row_sum),
        .rd_addr(c.addr),
        .rd_data(rd_data)
    );

    logic [15:0] out_count;
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            OUT_VALID <= 1'b0;
            OUT_PIXEL <= '0;
        end else begin
            OUT_VALID <= d.valid && (d.ph == ROW_PH_W'(row_last)); // [R7] [R8]
            if (d.valid) begin
                OUT_PIXEL <= next_row_sum;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            out_count <= 16'h0000;
        end else if (IN_FRAME_START) begin
            out_count <= 16'h0000;
        end else if (OUT_VALID) begin
            out_count <= out_count + 16'h0001;
        end
    end

    // ****************************************
    // ahb-lite slave, zero wait states
    // ****************************************
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_phase;
    logic [31:0] status_word;
    assign addr_phase = HSEL && HREADY && HTRANS[1];

    // control and status share one field layout
    function automatic logic [7:0] mode_word(input mode_s m);
        mode_word = 8'h00;
        mode_word[FLD_VIDEO] = m.video_sel;
        mode_word[FLD_SMODE +: 2] = m.sample_mode;
        mode_word[FLD_COLBIN +: 2] = m.col_bin;
        mode_word[FLD_ROWBIN +: 2] = m.row_bin;
    endfunction : mode_word

    assign status_word = {21'h00_0000, row_phase, (bin_mode.col_bin == BIN_RSVD || bin_mode.row_bin == BIN_RSVD),
                          8'h00} | 32'(mode_word(sel));

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            wr_pend <= addr_phase && HWRITE;
            wr_addr <= HADDR[7:0];
            if (addr_phase && !HWRITE) begin
                case (HADDR[7:0])
                    ADDR_CTRL: HRDATA <= 32'(mode_word(ctrl_mode)) | {31'h0000_0000, pin_mode};
                    ADDR_STATUS: HRDATA <= status_word;
                    ADDR_COUNT: HRDATA <= {16'h0000, out_count};
                    default: HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            pin_mode <= CTRL_PIN_MODE_RST;
            ctrl_mode <= MODE_RST;
        end else if (wr_pend && wr_addr == ADDR_CTRL) begin
            pin_mode <= HWDATA[CTRL_PIN_MODE];
            ctrl_mode.video_sel <= HWDATA[FLD_VIDEO];
            ctrl_mode.sample_mode <= HWDATA[FLD_SMODE +: 2];
            ctrl_mode.col_bin <= HWDATA[FLD_COLBIN +: 2];
            ctrl_mode.row_bin <= HWDATA[FLD_ROWBIN +: 2];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_src_ext;
        @(posedge CLOCK) disable iff (!NRST)
        sel.video_sel == VIDEO_EXTERNAL |=> s0_val == $past(IN_PIX_EXT);
    endproperty
    a_src_ext: assert property (p_src_ext) else $error("external source not passed"); // [R1]

    property p_raw;
        @(posedge CLOCK) disable iff (!NRST)
        sel.video_sel == VIDEO_INTERNAL && sel.sample_mode == SMODE_ACCUM |=> s0_val == $past(IN_PIX_INT);
    endproperty
    a_raw: assert property (p_raw) else $error("accumulate sample not raw"); // [R4]

    property p_cds_flag;
        @(posedge CLOCK) disable iff (!NRST)
        ##1 OUT_CDS_EN == ($past(sel.sample_mode) != SMODE_ACCUM);
    endproperty
    a_cds_flag: assert property (p_cds_flag) else $error("cds flag wrong for mode"); // [R3]

    property p_col1;
        @(posedge CLOCK) disable iff (!NRST)
        s0_valid && !IN_FRAME_START && col_last == 2'h0 |=> c.valid && c.sum == SUM_W'($past(s0_val));
    endproperty
    a_col1: assert property (p_col1) else $error("1x column sample not passed"); // [R5]

    property p_col4;
        @(posedge CLOCK) disable iff (!NRST)
        c.valid && !c.last && $past(bin_mode.col_bin) == BIN_4X |-> $past(col_cnt) == 2'h3;
    endproperty
    a_col4: assert property (p_col4) else $error("4x column group not four wide"); // [R6]

    property p_row1;
        @(posedge CLOCK) disable iff (!NRST)
        d.valid && row_last == 2'h0 && !$past(IN_FRAME_START) |=> OUT_VALID;
    endproperty
    a_row1: assert property (p_row1) else $error("1x row sum not output"); // [R7]

    property p_row_gate;
        @(posedge CLOCK) disable iff (!NRST)
        OUT_VALID |-> $past(d.valid) && $past(d.ph) == $past(ROW_PH_W'(row_last));
    endproperty
    a_row_gate: assert property (p_row_gate) else $error("row output before group done"); // [R8]

    property p_rsvd;
        @(posedge CLOCK) disable iff (!NRST)
        bin_mode.col_bin == BIN_RSVD || bin_mode.row_bin == BIN_RSVD |-> status_word[STAT_RSVD]
            && (bin_mode.col_bin != BIN_RSVD || col_last == 2'h0);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved binning code mishandled"); // [R10]
endmodule : mode_readout

//--- tb/pin_controller.sv
// camera controller model driving the slave-mode select pins
// assumes the readout block samples the pins on its own clock
`timescale 1ns/1ps
module pin_controller (
    input wire logic clock,
    input wire logic nrst,
    input wire readout_pkg::mode_s want,
    input wire logic row_go,
    output readout_pkg::mode_s pins,
    output logic row_start_strobe_n
);
    import readout_pkg::*;

    // ****************************************
    // pin levels
    // ****************************************
    // defined levels from reset on, never released
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pins <= MODE_RST;
        end else begin
            pins <= want;
        end
    end

    // ****************************************
    // row start strobe
    // ****************************************
    // low for 1.1 periods of the 10 ns clock
    initial begin
        row_start_strobe_n = 1'b1;
        forever begin
            @(posedge row_go);
            row_start_strobe_n = 1'b0;
            #11;
            row_start_strobe_n = 1'b1;
        end
    end
endmodule : pin_controller

//--- tb/tb.sv
// self-checking bench for the slave-mode readout block
// assumes pins settle into the logic within a few clocks of a change
`timescale 1ns/1ps
module tb;
    import readout_pkg::*;
    logic CLOCK, NRST, HSEL, HWRITE, IN_FRAME_START, IN_VALID, IN_LINE_END, row_go;
    logic [31:0] HADDR, HWDATA, HRDATA, seed, rd, exp_v;
    logic [1:0] HTRANS, OUT_SAMPLE_MODE;
    logic [2:0] HSIZE;
    logic [SAMPLE_W-1:0] pix_int, pix_rst, pix_ext;
    logic HREADYOUT, HRESP, OUT_VALID, OUT_CDS_EN, strobe_n;
    logic [SUM_W-1:0] OUT_PIXEL;
    mode_s want, pins;
    int failures, n_compared, cyc, emitted;
    int expq[$];
    int acc[6];

    pin_controller ctl (.clock(CLOCK), .nrst(NRST), .want(want), .row_go(row_go), .pins(pins),
        .row_start_strobe_n(strobe_n));

    mode_readout dut (.CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .VIDEO_SOURCE_SELECT(pins.video_sel),
        .SAMPLE_MODE_HI(pins.sample_mode[1]), .SAMPLE_MODE_LO(pins.sample_mode[0]),
        .COL_BIN_HI(pins.col_bin[1]), .COL_BIN_LO(pins.col_bin[0]), .ROW_BIN_HI(pins.row_bin[1]),
        .ROW_BIN_LO(pins.row_bin[0]), .IN_FRAME_START(IN_FRAME_START), .IN_VALID(IN_VALID),
        .IN_LINE_END(IN_LINE_END), .IN_PIX_INT(pix_int), .IN_RESET_LEVEL(pix_rst), .IN_PIX_EXT(pix_ext),
        .OUT_VALID(OUT_VALID), .OUT_PIXEL(OUT_PIXEL), .OUT_CDS_EN(OUT_CDS_EN),
        .OUT_SAMPLE_MODE(OUT_SAMPLE_MODE));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic int gsz(input logic [1:0] code);
        return (code == 2'h1) ? 2 : ((code == 2'h2) ? 4 : 1);
    endfunction : gsz

    function automatic int sample_val(input mode_s c, input int pi, input int pr, input int pe);
        if (c.video_sel) return pe;
        if (c.sample_mode == SMODE_ACCUM) return pi;
        return (pi > pr) ? pi - pr : 0;
    endfunction : sample_val

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task complete_run();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // single ahb transfer; the master waits on hready in both phases
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        HSEL <= 1'b1;
        HTRANS <= HTRANS_NONSEQ;
        HADDR <= {24'h0000_00, a};
        HWRITE <= wr;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
    endtask : ahb

    task run_frame(input mode_s cfg);
        int gc;
        int gr;
        gc = gsz(cfg.col_bin);
        gr = gsz(cfg.row_bin);
        emitted = 0;
        want <= cfg;
        repeat (6) @(posedge CLOCK);
        check(32'(OUT_SAMPLE_MODE), 32'(cfg.sample_mode));
        check(32'(OUT_CDS_EN), 32'(cfg.sample_mode != SMODE_ACCUM));
        IN_FRAME_START <= 1'b1;
        row_go <= 1'b1;
        @(posedge CLOCK);
        IN_FRAME_START <= 1'b0;
        row_go <= 1'b0;
        check(32'(strobe_n), 32'h0000_0000);
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 6; c++) begin
                @(posedge CLOCK);
                seed = xs(seed);
                pix_int <= seed[9:0];
                pix_rst <= seed[19:10];
                pix_ext <= seed[29:20];
                IN_VALID <= 1'b1;
                IN_LINE_END <= (c == 5);
                acc[c / gc] += sample_val(cfg, seed[9:0], seed[19:10], seed[29:20]);
                // short column group at line end still emitted
                if (r % gr == gr - 1 && (c % gc == gc - 1 || c == 5)) begin
                    expq.push_back(acc[c / gc]);
                    acc[c / gc] = 0;
                    emitted++;
                end
            end
        end
        @(posedge CLOCK);
        IN_VALID <= 1'b0;
        IN_LINE_END <= 1'b0;
        repeat (8) @(posedge CLOCK);
        check(32'(strobe_n), 32'h0000_0001);
        check(32'(expq.size()), 32'h0000_0000);
        ahb(1'b0, ADDR_COUNT, 32'h0000_0000, rd);
        check(32'(rd[15:0]), 32'(emitted));
        ahb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
        check(32'(rd[8:1]), {24'h0000_00, cfg.col_bin == BIN_RSVD || cfg.row_bin == BIN_RSVD,
            cfg.row_bin, cfg.col_bin, cfg.sample_mode, cfg.video_sel});
        $display("frame %h done", cfg);
    endtask : run_frame

    // ****************************************
    // clock, timeout, output monitor
    // ****************************************
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end

    always @(posedge CLOCK) begin
        if (NRST === 1'b1 && OUT_VALID === 1'b1) begin
            exp_v = (expq.size() > 0) ? 32'(expq.pop_front()) : 32'hffff_ffff;
            check(32'(OUT_PIXEL), exp_v);
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {HSEL, HWRITE, IN_FRAME_START, IN_VALID, IN_LINE_END, row_go} = '0;
        {HADDR, HWDATA, HTRANS, pix_int, pix_rst, pix_ext} = '0;
        HSIZE = 3'h2;
        want = MODE_RST;
        seed = 32'hb4ce_ee5b;
        for (int i = 0; i < 6; i++) acc[i] = 0;
        NRST = 1'b0;
        repeat (4) @(posedge CLOCK);
        NRST <= 1'b1;
        @(posedge CLOCK);
        ahb(1'b0, ADDR_CTRL, 32'h0000_0000, rd);
        check(rd, 32'h0000_0001);
        ahb(1'b1, 8'h10, 32'hffff_ffff, rd);
        ahb(1'b0, 8'h10, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        ahb(1'b0, ADDR_CTRL, 32'h0000_0000, rd);
        check(rd, 32'h0000_0001);
        $display("register reset test done");
        // every video, sampling and binning code in turn
        for (int k = 0; k < 128; k++) run_frame(mode_s'(k[6:0]));
        // register path: external, accumulate, 2X columns while pins say standard
        ahb(1'b1, ADDR_CTRL, 32'h0000_001a, rd);
        want <= MODE_RST;
        repeat (6) @(posedge CLOCK);
        check(32'(OUT_SAMPLE_MODE), 32'(SMODE_ACCUM));
        check(32'(OUT_CDS_EN), 32'h0000_0000);
        ahb(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
        check(32'(rd[7:0]), 32'h0000_001a);
        ahb(1'b0, ADDR_CTRL, 32'h0000_0000, rd);
        check(rd, 32'h0000_001a);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0001, rd);
        $display("register mode test done");
        complete_run();
    end
endmodule : tb
